// *** verilog/gdm_regs.svh ***
// constants of the gyro diagnostic status monitor: bit positions, codes, timing
// assumes a 40 MHz internal clock; included by the monitor's design files
`ifndef GDM_REGS_SVH
`define GDM_REGS_SVH

// status byte layout
`define GDM_BIT_ADC         7
`define GDM_BIT_DSP         6
`define GDM_BIT_OTP         5
`define GDM_BIT_ATEST       4
`define GDM_BIT_SUPPLY      3
`define GDM_BIT_DETECT      2
`define GDM_BIT_EXC         1
`define GDM_BIT_SPARE       0
`define GDM_STATUS_RESET    8'hff

// flags that may start error signalling (analog test bit excluded)
`define GDM_ERR_MASK        8'hee
// flags whose error may be ended by the recovery sequence
`define GDM_RECOV_MASK      8'h82

// error code returned on rate reads
`define GDM_ERR_CODE_HIGH   8'h80
`define GDM_ERR_CODE_LOW    8'h00

// timing
`define GDM_CLK_MHZ         40
`define GDM_STRETCH_US      1500
`define GDM_STRETCH_MAX_US  2000
`define GDM_STARTUP_MS      90
`define GDM_SETTLE_MS       500
`define GDM_STRETCH_CYC     (`GDM_STRETCH_US * `GDM_CLK_MHZ)
`define GDM_SETTLE_CYC      (`GDM_SETTLE_MS * 1000 * `GDM_CLK_MHZ)
`define GDM_STRETCH_W       16
`define GDM_SETTLE_W        25

`endif

// *** verilog/gdm_pkg.sv ***
// types shared by the gyro diagnostic status monitor
// assumes commands arrive already decoded from the serial front end
`default_nettype none

package gdm_pkg;

	typedef enum logic [3:0] {
		GDM_READ_STATUS_CMD,
		GDM_RATE_READ_HIGH_CMD,
		GDM_RATE_READ_LOW_CMD,
		GDM_GUARD_DISABLE_FIRST_CMD,
		GDM_GUARD_DISABLE_SECOND_CMD,
		GDM_GUARD_DISABLE_THIRD_CMD,
		GDM_ERROR_RECOVER_CMD,
		GDM_GUARD_ENABLE_CMD,
		GDM_OTHER_CMD
	} gdm_cmd_t;

	typedef enum logic [1:0] {
		GDM_GUARD_ON,
		GDM_GUARD_DIS1,
		GDM_GUARD_DIS2,
		GDM_GUARD_OFF
	} gdm_guard_t;

endpackage
`default_nettype wire

// *** verilog/gdm_stretch.sv ***
// low-pulse stretcher for one diagnostic flag
// assumes raw_ok_i is synchronous to clk_i
`timescale 1ns/100ps
`default_nettype none
`include "gdm_regs.svh"

module gdm_stretch #(
	parameter int unsigned STRETCH_CYC = `GDM_STRETCH_CYC
) (
	input  wire logic clk_i,
	input  wire logic srst_i,
	input  wire logic raw_ok_i,
	output logic      ok_o
);

	logic [`GDM_STRETCH_W-1:0] cnt;
	wire  [`GDM_STRETCH_W-1:0] load_val = STRETCH_CYC[`GDM_STRETCH_W-1:0];

	// reload on every low cycle, so each new pulse restarts the window
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cnt <= '0;
		end else if (!raw_ok_i) begin
			cnt <= load_val; // [RULE20]
		end else if (cnt != '0) begin
			cnt <= cnt - 1'b1;
		end
	end

	// a one-cycle glitch ends up low for STRETCH_CYC + 1 cycles, inside the window
	assign ok_o = raw_ok_i && (cnt == '0); // [RULE3]

	property p_reload;
		@(posedge clk_i) disable iff (srst_i)
		!raw_ok_i |=> (cnt == load_val) && !ok_o;
	endproperty
	stretch_reload_a: assert property (p_reload) // [RULE20]
		else $error("stretch counter not reloaded on low flag");

	stretch_hold_a: assert property ( // [RULE3]
		@(posedge clk_i) disable iff (srst_i)
		(cnt > 1) && raw_ok_i |=> !ok_o && (cnt == $past(cnt) - 1'b1))
		else $error("stretched flag released early");

	stretch_release_a: assert property ( // [RULE3]
		@(posedge clk_i) disable iff (srst_i)
		(cnt == 1) && raw_ok_i ##1 raw_ok_i |-> ok_o)
		else $error("stretched flag held beyond its window");

endmodule
`default_nettype wire

// *** verilog/gdm_guard.sv ***
// protection guard sequencer: three disable steps, recovery gate, re-enable
// assumes one decoded command per cmd_valid_i pulse
`timescale 1ns/100ps
`default_nettype none

module gdm_guard (
	input  wire logic             clk_i,
	input  wire logic             srst_i,
	input  wire logic             cmd_valid_i,
	input  wire gdm_pkg::gdm_cmd_t cmd_i,
	input  wire logic             recov_flags_ok_i,
	output logic                  guard_off_o,
	output logic                  recover_o
);

	gdm_pkg::gdm_guard_t state;
	gdm_pkg::gdm_guard_t next_state;

	// out-of-order disable steps fall back to the guarded state, except in GDM_GUARD_OFF, which holds
	always_comb begin
		next_state = state;
		if (cmd_valid_i) begin
			case (cmd_i)
				gdm_pkg::GDM_GUARD_DISABLE_FIRST_CMD:
					next_state = (state == gdm_pkg::GDM_GUARD_ON) ? gdm_pkg::GDM_GUARD_DIS1
						: (state == gdm_pkg::GDM_GUARD_OFF) ? state : gdm_pkg::GDM_GUARD_ON;
				gdm_pkg::GDM_GUARD_DISABLE_SECOND_CMD:
					next_state = (state == gdm_pkg::GDM_GUARD_DIS1) ? gdm_pkg::GDM_GUARD_DIS2
						: (state == gdm_pkg::GDM_GUARD_OFF) ? state : gdm_pkg::GDM_GUARD_ON;
				gdm_pkg::GDM_GUARD_DISABLE_THIRD_CMD:
					next_state = (state == gdm_pkg::GDM_GUARD_DIS2) ? gdm_pkg::GDM_GUARD_OFF
						: (state == gdm_pkg::GDM_GUARD_OFF) ? state : gdm_pkg::GDM_GUARD_ON;
				gdm_pkg::GDM_GUARD_ENABLE_CMD:
					next_state = gdm_pkg::GDM_GUARD_ON; // [RULE16]
				default:
					next_state = state;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state <= gdm_pkg::GDM_GUARD_ON;
		end else begin
			state <= next_state;
		end
	end

	assign guard_off_o = (state == gdm_pkg::GDM_GUARD_OFF);
	// recovery only after all three disables and with recoverable flags clean
	assign recover_o = cmd_valid_i && (cmd_i == gdm_pkg::GDM_ERROR_RECOVER_CMD)
		&& guard_off_o && recov_flags_ok_i; // [RULE16] [RULE19]

	sequence s_three_disables;
		cmd_valid_i && cmd_i == gdm_pkg::GDM_GUARD_DISABLE_THIRD_CMD
			&& state == gdm_pkg::GDM_GUARD_DIS2;
	endsequence
	guard_open_a: assert property ( // [RULE16]
		@(posedge clk_i) disable iff (srst_i)
		s_three_disables |=> guard_off_o)
		else $error("guard not opened after third disable");

	guard_close_a: assert property ( // [RULE16]
		@(posedge clk_i) disable iff (srst_i)
		cmd_valid_i && cmd_i == gdm_pkg::GDM_GUARD_ENABLE_CMD |=> !guard_off_o)
		else $error("guard not restored by enable command");

endmodule
`default_nettype wire

// *** verilog/gdm_monitor.sv ***
// gyro diagnostic status monitor: status byte, error latch, rate substitution
// assumes decoded serial commands and monitor inputs synchronous to clk_i;
// srst_i models the internal power-on reset
//
// Overview of operation
// [RULE1] seven monitors drive active-high ok flags; bit 0 always reads one
// [RULE2] the read-status command returns the current status byte
// [RULE3] every low flag pulse is stretched to between 1.5 and 2.0 ms
// [RULE4] bit 7 goes low on converter overflow; recoverable
// [RULE5] bit 6 low on dsp overflow or underflow, not output scaling; permanent
// [RULE6] bit 5 low on otp parity failure; permanent
// [RULE7] bit 4 low in analog test mode; never substitutes the error code
// [RULE8] bit 3 high only while analog supply is in window; permanent
// [RULE9] bit 2 low on open or leaky detection electrode; permanent
// [RULE10] bit 1 low when excitation unlocked and amplitude too low; recoverable
// [RULE11] start-up ends at first excitation lock; rate reads give error code
// [RULE12] until start-up completes, both rate reads return the error code
// [RULE13] after start-up any error flag substitutes error code and holds dsp
// [RULE14] error signalling persists until power-down or recovery of recoverable errors
// [RULE15] host polls, waits 30 ms, sends three disables, recovery, enable
// [RULE16] recovery acts only after all three disables; enable restores guard
// [RULE17] no error is latched while the guard is disabled
// [RULE18] rate data readable right after start-up; full accuracy within 500 ms
// [RULE19] recovery with recoverable flags low or guard enabled changes nothing
// [RULE20] stretch timed by a counter restarted on each new low pulse
`timescale 1ns/100ps
`default_nettype none
`include "gdm_regs.svh"

module gdm_monitor #(
	parameter int unsigned STRETCH_CYC = `GDM_STRETCH_CYC,
	parameter int unsigned SETTLE_CYC  = `GDM_SETTLE_CYC
) (
	input  wire logic              clk_i,
	input  wire logic              srst_i,
	// decoded serial commands
	input  wire logic              cmd_valid_i,
	input  wire gdm_pkg::gdm_cmd_t cmd_i,
	// rate word from the signal path
	input  wire logic [7:0]        rate_high_i,
	input  wire logic [7:0]        rate_low_i,
	// monitor inputs
	input  wire logic              adc_overflow_i,
	input  wire logic              dsp_overflow_i,
	input  wire logic              otp_parity_fail_i,
	input  wire logic              analog_test_i,
	input  wire logic              supply_in_window_i,
	input  wire logic              detect_open_i,
	input  wire logic              detect_leak_i,
	input  wire logic              excitation_locked_i,
	input  wire logic              excitation_amp_low_i,
	// results
	output logic                   resp_valid_o,
	output logic [7:0]             resp_data_o,
	output logic [7:0]             diagnostic_status_o,
	output logic                   startup_done_o,
	output logic                   settled_o,
	output logic                   dsp_hold_o,
	output logic                   guard_off_o
);

	function automatic logic is_rate_cmd(input gdm_pkg::gdm_cmd_t c);
		return (c == gdm_pkg::GDM_RATE_READ_HIGH_CMD) || (c == gdm_pkg::GDM_RATE_READ_LOW_CMD);
	endfunction

	// raw flags, active high
	wire [7:0] raw_ok;
	assign raw_ok[`GDM_BIT_ADC]    = !adc_overflow_i;                // [RULE4]
	// final output saturation is not wired in, so it cannot clear this flag
	assign raw_ok[`GDM_BIT_DSP]    = !dsp_overflow_i;                // [RULE5]
	assign raw_ok[`GDM_BIT_OTP]    = !otp_parity_fail_i;             // [RULE6]
	assign raw_ok[`GDM_BIT_ATEST]  = !analog_test_i;                 // [RULE7]
	assign raw_ok[`GDM_BIT_SUPPLY] = supply_in_window_i;             // [RULE8]
	assign raw_ok[`GDM_BIT_DETECT] = !(detect_open_i || detect_leak_i); // [RULE9]
	assign raw_ok[`GDM_BIT_EXC]    = !(!excitation_locked_i && excitation_amp_low_i); // [RULE10]
	assign raw_ok[`GDM_BIT_SPARE]  = 1'b1;

	wire [7:0] status;
	assign status[`GDM_BIT_SPARE] = raw_ok[`GDM_BIT_SPARE]; // [RULE1]

	genvar gi;
	generate
		for (gi = 1; gi < 8; gi++) begin : g_flag
			gdm_stretch #(
				.STRETCH_CYC (STRETCH_CYC)
			) u_stretch (
				.clk_i    (clk_i),
				.srst_i   (srst_i),
				.raw_ok_i (raw_ok[gi]),
				.ok_o     (status[gi])
			); // [RULE1] [RULE3]
		end
	endgenerate

	assign diagnostic_status_o = status;

	wire [7:0] err_flags    = ~status & `GDM_ERR_MASK;
	wire [7:0] recov_flags  = ~status & `GDM_RECOV_MASK;
	wire       any_err      = |err_flags;                 // [RULE7] [RULE13]
	wire       nonrecov_err = |(err_flags & ~`GDM_RECOV_MASK);
	wire       recov_ok     = ~|recov_flags;

	wire recover_fire;
	gdm_guard u_guard (
		.clk_i            (clk_i),
		.srst_i           (srst_i),
		.cmd_valid_i      (cmd_valid_i),
		.cmd_i            (cmd_i),
		.recov_flags_ok_i (recov_ok),
		.guard_off_o      (guard_off_o),
		.recover_o        (recover_fire)
	);

	// start-up ends the first time the excitation flag reads one
	logic startup_done;
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			startup_done <= 1'b0;
		end else if (status[`GDM_BIT_EXC]) begin
			startup_done <= 1'b1; // [RULE11]
		end
	end
	assign startup_done_o = startup_done;

	// error latch; the guard being off blocks any new set
	logic err_latched;
	logic nonrecov_latched;
	wire  latch_set   = startup_done && any_err && !guard_off_o;   // [RULE13] [RULE17]
	wire  latch_clear = recover_fire && !nonrecov_latched;         // [RULE14] [RULE19]
	wire  next_err_latched = latch_set || (err_latched && !latch_clear);
	wire  next_nonrecov    = nonrecov_latched || (latch_set && nonrecov_err);

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			err_latched      <= 1'b0;
			nonrecov_latched <= 1'b0;
		end else begin
			err_latched      <= next_err_latched; // [RULE14]
			nonrecov_latched <= next_nonrecov;
		end
	end
	assign dsp_hold_o = err_latched; // [RULE13]

	// accuracy settling; informational only, no substitution meanwhile
	logic [`GDM_SETTLE_W-1:0] settle_cnt;
	wire  [`GDM_SETTLE_W-1:0] settle_end = SETTLE_CYC[`GDM_SETTLE_W-1:0];
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			settle_cnt <= '0;
		end else if (startup_done && settle_cnt != settle_end) begin
			settle_cnt <= settle_cnt + 1'b1; // [RULE18]
		end
	end
	assign settled_o = (settle_cnt == settle_end);

	// response selection
	wire       subst     = !startup_done || err_latched; // [RULE12] [RULE13]
	wire       is_read   = (cmd_i == gdm_pkg::GDM_READ_STATUS_CMD) || is_rate_cmd(cmd_i);
	wire [7:0] rate_high = subst ? `GDM_ERR_CODE_HIGH : rate_high_i;
	wire [7:0] rate_low  = subst ? `GDM_ERR_CODE_LOW  : rate_low_i;
	wire [7:0] next_resp =
		(cmd_i == gdm_pkg::GDM_READ_STATUS_CMD)    ? status :    // [RULE2]
		(cmd_i == gdm_pkg::GDM_RATE_READ_HIGH_CMD) ? rate_high : // [RULE11] [RULE18]
		rate_low;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			resp_valid_o <= 1'b0;
			resp_data_o  <= 8'h00;
		end else begin
			resp_valid_o <= cmd_valid_i && is_read;
			if (cmd_valid_i && is_read) begin
				resp_data_o <= next_resp;
			end
		end
	end

	// checks
	spare_bit_one_a: assert property ( // [RULE1]
		@(posedge clk_i) disable iff (srst_i)
		resp_valid_o && $past(cmd_i) == gdm_pkg::GDM_READ_STATUS_CMD |-> resp_data_o[0])
		else $error("spare status bit read as zero");

	status_read_a: assert property ( // [RULE2]
		@(posedge clk_i) disable iff (srst_i)
		cmd_valid_i && cmd_i == gdm_pkg::GDM_READ_STATUS_CMD
			|=> resp_valid_o && resp_data_o == $past(status))
		else $error("status read returned wrong byte");

	adc_flag_low_a: assert property ( // [RULE4]
		@(posedge clk_i) disable iff (srst_i)
		adc_overflow_i |=> !status[`GDM_BIT_ADC] [*3])
		else $error("converter flag not held low after overflow");

	dsp_flag_low_a: assert property ( // [RULE5]
		@(posedge clk_i) disable iff (srst_i)
		dsp_overflow_i |=> !status[`GDM_BIT_DSP] ##1 !status[`GDM_BIT_DSP])
		else $error("dsp flag not held low after overflow");

	exc_flag_low_a: assert property ( // [RULE10]
		@(posedge clk_i) disable iff (srst_i)
		!excitation_locked_i && excitation_amp_low_i |=> !status[`GDM_BIT_EXC])
		else $error("excitation flag not low on lost lock");

	sequence s_rate_read;
		cmd_valid_i && is_rate_cmd(cmd_i);
	endsequence

	startup_code_a: assert property ( // [RULE12]
		@(posedge clk_i) disable iff (srst_i)
		s_rate_read ##0 !startup_done |=> resp_valid_o
			&& (resp_data_o == `GDM_ERR_CODE_HIGH || resp_data_o == `GDM_ERR_CODE_LOW))
		else $error("rate read during start-up not replaced by error code");

	error_latch_a: assert property ( // [RULE13]
		@(posedge clk_i) disable iff (srst_i)
		startup_done && any_err && !guard_off_o |=> err_latched && dsp_hold_o)
		else $error("error after start-up not latched");

	atest_no_latch_a: assert property ( // [RULE7]
		@(posedge clk_i) disable iff (srst_i)
		!err_latched && ((status | 8'h10) == 8'hff) |=> !err_latched)
		else $error("analog test flag started error signalling");

	error_persist_a: assert property ( // [RULE14]
		@(posedge clk_i) disable iff (srst_i)
		err_latched && !recover_fire |=> err_latched)
		else $error("error signalling ended without recovery");

	guard_no_latch_a: assert property ( // [RULE17]
		@(posedge clk_i) disable iff (srst_i)
		guard_off_o && !err_latched |=> !err_latched)
		else $error("error latched while guard disabled");

	recover_refused_a: assert property ( // [RULE19]
		@(posedge clk_i) disable iff (srst_i)
		err_latched && cmd_valid_i && cmd_i == gdm_pkg::GDM_ERROR_RECOVER_CMD
			&& (!guard_off_o || !recov_ok) |=> err_latched)
		else $error("recovery accepted while refused");

	settle_pass_a: assert property ( // [RULE18]
		@(posedge clk_i) disable iff (srst_i)
		s_rate_read ##0 startup_done && !err_latched
			&& cmd_i == gdm_pkg::GDM_RATE_READ_HIGH_CMD |=> resp_data_o == $past(rate_high_i))
		else $error("rate data withheld after start-up");

	status_spare_a: assert property ( // [RULE1]
		@(posedge clk_i) disable iff (srst_i)
		diagnostic_status_o[`GDM_BIT_SPARE])
		else $error("spare status bit not one");

	resp_only_read_a: assert property ( // [RULE2]
		@(posedge clk_i) disable iff (srst_i)
		!(cmd_valid_i && is_read) |=> !resp_valid_o)
		else $error("answer given to a command that reads nothing");

	otp_flag_low_a: assert property ( // [RULE6]
		@(posedge clk_i) disable iff (srst_i)
		otp_parity_fail_i |-> !diagnostic_status_o[`GDM_BIT_OTP])
		else $error("otp flag not low on parity failure");

	atest_flag_low_a: assert property ( // [RULE7]
		@(posedge clk_i) disable iff (srst_i)
		analog_test_i |-> !diagnostic_status_o[`GDM_BIT_ATEST])
		else $error("analog test flag not low in test mode");

	supply_flag_low_a: assert property ( // [RULE8]
		@(posedge clk_i) disable iff (srst_i)
		!supply_in_window_i |-> !diagnostic_status_o[`GDM_BIT_SUPPLY])
		else $error("supply flag not low outside window");

	detect_flag_low_a: assert property ( // [RULE9]
		@(posedge clk_i) disable iff (srst_i)
		detect_open_i || detect_leak_i |-> !diagnostic_status_o[`GDM_BIT_DETECT])
		else $error("detection flag not low on electrode fault");

	startup_set_a: assert property ( // [RULE11]
		@(posedge clk_i) disable iff (srst_i)
		!startup_done && diagnostic_status_o[`GDM_BIT_EXC] |=> startup_done_o)
		else $error("start-up not ended at first excitation lock");

	startup_keep_a: assert property ( // [RULE11]
		@(posedge clk_i) disable iff (srst_i)
		startup_done_o |=> startup_done_o)
		else $error("start-up done dropped without reset");

	sequence s_subst_read;
		cmd_valid_i && is_rate_cmd(cmd_i) && (!startup_done || err_latched);
	endsequence

	code_high_a: assert property ( // [RULE12] [RULE13]
		@(posedge clk_i) disable iff (srst_i)
		s_subst_read ##0 cmd_i == gdm_pkg::GDM_RATE_READ_HIGH_CMD
			|=> resp_data_o == `GDM_ERR_CODE_HIGH)
		else $error("rate high read not replaced by error code");

	code_low_a: assert property ( // [RULE12] [RULE13]
		@(posedge clk_i) disable iff (srst_i)
		s_subst_read ##0 cmd_i == gdm_pkg::GDM_RATE_READ_LOW_CMD
			|=> resp_data_o == `GDM_ERR_CODE_LOW)
		else $error("rate low read not replaced by error code");

	nonrecov_keep_a: assert property ( // [RULE14]
		@(posedge clk_i) disable iff (srst_i)
		nonrecov_latched |=> nonrecov_latched && dsp_hold_o)
		else $error("permanent error signalling ended");

	recover_clear_a: assert property ( // [RULE14]
		@(posedge clk_i) disable iff (srst_i)
		err_latched && recover_fire && !nonrecov_latched |=> !dsp_hold_o)
		else $error("accepted recovery left error signalling on");

	settle_low_a: assert property ( // [RULE18]
		@(posedge clk_i) disable iff (srst_i)
		s_rate_read ##0 startup_done && !err_latched
			&& cmd_i == gdm_pkg::GDM_RATE_READ_LOW_CMD |=> resp_data_o == $past(rate_low_i))
		else $error("rate low data withheld after start-up");

	settle_keep_a: assert property ( // [RULE18]
		@(posedge clk_i) disable iff (srst_i)
		settled_o |=> settled_o)
		else $error("settled indication dropped without reset");

endmodule
`default_nettype wire

// *** dv/gdm_host_model.sv ***
// host model: issues decoded commands one at a time on the falling edge
// assumes the bench calls its tasks and checks every answer itself
`timescale 1ns/100ps
`default_nettype none

module gdm_host_model #(
	parameter int WAIT_CYC = 30
) (
	input  wire logic         clk_i,
	output logic              cmd_valid_o,
	output gdm_pkg::gdm_cmd_t cmd_o
);
	initial begin
		cmd_valid_o = 1'b0;
		cmd_o = gdm_pkg::GDM_OTHER_CMD;
	end

	// idle cycle after each command so two pulses never merge
	task automatic send(input gdm_pkg::gdm_cmd_t c);
		@(negedge clk_i);
		cmd_valid_o = 1'b1;
		cmd_o = c;
		@(negedge clk_i);
		cmd_valid_o = 1'b0;
		cmd_o = gdm_pkg::GDM_OTHER_CMD;
		@(negedge clk_i);
	endtask

	// settle wait scaled down to cycles; the block itself does not time it
	task automatic recover();
		repeat (WAIT_CYC) @(negedge clk_i);
		send(gdm_pkg::GDM_GUARD_DISABLE_FIRST_CMD);
		send(gdm_pkg::GDM_GUARD_DISABLE_SECOND_CMD);
		send(gdm_pkg::GDM_GUARD_DISABLE_THIRD_CMD);
		send(gdm_pkg::GDM_ERROR_RECOVER_CMD);
		send(gdm_pkg::GDM_GUARD_ENABLE_CMD);
	endtask
endmodule
`default_nettype wire

// *** dv/gdm_monitor_bench.sv ***
// bench for the diagnostic monitor: integer model checked every clock
// assumes short stretch and settle counts; monitor inputs as one vector
`timescale 1ns/100ps
`default_nettype none
`include "gdm_regs.svh"

module gdm_monitor_bench;
	localparam int S = 8;
	localparam int SETTLE = 20;
	logic              clk_i = 1'b0;
	logic              srst_i = 1'b1;
	logic [8:0]        ins = 9'h000;
	logic [7:0]        rate_h = 8'h00;
	logic [7:0]        rate_l = 8'h00;
	logic              cmd_valid;
	gdm_pkg::gdm_cmd_t cmd;
	logic              resp_valid;
	logic [7:0]        resp_data;
	logic [7:0]        status;
	logic              start;
	logic              settled;
	logic              hold;
	logic              goff;
	int                errors = 0;
	int                n_checks = 0;
	int                cycles = 0;
	integer            seed = 95;
	int                cnt [8];
	int                m_guard;
	logic              m_start, m_hold, m_nonrec, m_rv;
	logic [7:0]        m_resp, st, bad;
	logic [8:0]        nr [5] = '{9'h040, 9'h020, 9'h008, 9'h004, 9'h100};

	always #12.5 clk_i = ~clk_i;

	gdm_monitor #(.STRETCH_CYC(S), .SETTLE_CYC(SETTLE)) gdm_monitor_i (
		.clk_i(clk_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
		.rate_high_i(rate_h), .rate_low_i(rate_l), .adc_overflow_i(ins[7]),
		.dsp_overflow_i(ins[6]), .otp_parity_fail_i(ins[5]), .analog_test_i(ins[4]),
		.supply_in_window_i(~ins[3]), .detect_open_i(ins[2]), .detect_leak_i(ins[8]),
		.excitation_locked_i(~ins[1]), .excitation_amp_low_i(ins[0]),
		.resp_valid_o(resp_valid), .resp_data_o(resp_data),
		.diagnostic_status_o(status), .startup_done_o(start), .settled_o(settled),
		.dsp_hold_o(hold), .guard_off_o(goff));

	gdm_host_model gdm_host_model_i (.clk_i(clk_i), .cmd_valid_o(cmd_valid), .cmd_o(cmd));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic do_reset(input int n);
		@(negedge clk_i) srst_i = 1'b1;
		repeat (n) @(negedge clk_i);
		srst_i = 1'b0;
	endtask

	task automatic glitch(input logic [8:0] v, input int w);
		@(negedge clk_i) ins = v;
		repeat (w) @(negedge clk_i);
		ins = 9'h000;
	endtask

	always @(negedge clk_i) begin
		rate_h = 8'($random(seed));
		rate_l = 8'($random(seed));
	end

	// model: compared before each edge, then stepped with the design's inputs
	always @(posedge clk_i) begin
		bad = {ins[7:3], ins[2] | ins[8], ins[1] & ins[0], 1'b0};
		for (int b = 0; b < 8; b++) st[b] = !(bad[b] || cnt[b] != 0);
		if (srst_i) begin
			cnt = '{default: 0};
			{m_start, m_hold, m_nonrec, m_rv, m_resp, m_guard} = '0;
		end else begin
			check(status, st);
			check(resp_valid, m_rv);
			check(resp_data, m_resp);
			check(hold, m_hold);
			check(start, m_start);
			check(goff, m_guard == 3);
			m_rv = cmd_valid && int'(cmd) <= 2;
			if (m_rv)
				m_resp = (cmd == gdm_pkg::GDM_READ_STATUS_CMD) ? st :
					(!m_start || m_hold) ? ((int'(cmd) == 1) ? `GDM_ERR_CODE_HIGH :
					`GDM_ERR_CODE_LOW) : ((int'(cmd) == 1) ? rate_h : rate_l);
			if (m_start && (st & `GDM_ERR_MASK) != `GDM_ERR_MASK && m_guard != 3) begin
				m_hold = 1'b1;
				if ((st | `GDM_RECOV_MASK | 8'h11) != 8'hff) m_nonrec = 1'b1;
			end
			if (cmd_valid && cmd == gdm_pkg::GDM_ERROR_RECOVER_CMD && m_guard == 3 &&
					st[7] && st[1] && !m_nonrec) m_hold = 1'b0;
			if (cmd_valid && int'(cmd) >= 3 && int'(cmd) <= 5 && m_guard != 3)
				m_guard = (int'(cmd) - 3 == m_guard) ? m_guard + 1 : 0;
			if (cmd_valid && cmd == gdm_pkg::GDM_GUARD_ENABLE_CMD) m_guard = 0;
			m_start = m_start | st[1];
			for (int b = 0; b < 8; b++) cnt[b] = bad[b] ? S : (cnt[b] > 0 ? cnt[b] - 1 : 0);
		end
	end

	// whole run needs well under a thousand cycles
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			finish_test();
		end
	end

	initial begin
		ins = 9'h003;
		do_reset(20);
		gdm_host_model_i.send(gdm_pkg::GDM_RATE_READ_HIGH_CMD);
		gdm_host_model_i.send(gdm_pkg::GDM_RATE_READ_LOW_CMD);
		@(negedge clk_i) ins = 9'h000;
		repeat (S + SETTLE) @(negedge clk_i);
		check(settled, 8'h00);
		@(negedge clk_i);
		check(settled, 8'h01);
		gdm_host_model_i.send(gdm_pkg::GDM_RATE_READ_HIGH_CMD);
		gdm_host_model_i.send(gdm_pkg::GDM_RATE_READ_LOW_CMD);
		$display("test startup done");
		gdm_host_model_i.send(gdm_pkg::GDM_GUARD_DISABLE_FIRST_CMD);
		gdm_host_model_i.send(gdm_pkg::GDM_GUARD_DISABLE_SECOND_CMD);
		gdm_host_model_i.send(gdm_pkg::GDM_GUARD_DISABLE_THIRD_CMD);
		for (int i = 1; i < 9; i++) begin
			glitch((i == 1) ? 9'h003 : (9'h001 << i), 1 + i % 3);
			gdm_host_model_i.send(gdm_pkg::GDM_READ_STATUS_CMD);
			repeat (S) @(negedge clk_i);
		end
		gdm_host_model_i.send(gdm_pkg::GDM_GUARD_ENABLE_CMD);
		glitch(9'h010, 2);
		repeat (S + 2) @(negedge clk_i);
		$display("test stretch done");
		glitch(9'h080, 1);
		gdm_host_model_i.send(gdm_pkg::GDM_RATE_READ_HIGH_CMD);
		gdm_host_model_i.send(gdm_pkg::GDM_ERROR_RECOVER_CMD);
		gdm_host_model_i.send(gdm_pkg::GDM_GUARD_DISABLE_FIRST_CMD);
		gdm_host_model_i.send(gdm_pkg::GDM_GUARD_DISABLE_THIRD_CMD);
		@(negedge clk_i) ins = 9'h003;
		gdm_host_model_i.recover();
		@(negedge clk_i) ins = 9'h000;
		repeat (S + 2) @(negedge clk_i);
		gdm_host_model_i.recover();
		gdm_host_model_i.send(gdm_pkg::GDM_RATE_READ_LOW_CMD);
		$display("test recovery done");
		foreach (nr[k]) begin
			do_reset(2);
			glitch(nr[k], 1);
			repeat (S + 2) @(negedge clk_i);
			gdm_host_model_i.recover();
			gdm_host_model_i.send(gdm_pkg::GDM_RATE_READ_HIGH_CMD);
		end
		$display("test permanent errors done");
		finish_test();
	end
endmodule
`default_nettype wire
